// File: include/ecs_map.svh
`ifndef ECS_MAP_SVH
`define ECS_MAP_SVH
// ==========================================================
// Word layout
`define ECS_WORD_W       72
`define ECS_DATA_W       60
`define ECS_HALF_W       30
`define ECS_CHECK_LSB    60
`define ECS_COMP_LSB     68
`define ECS_LINE_WORDS   16
`define ECS_ADDR_W       21
// ==========================================================
// Timing in clock periods; ECS_NEAR_END counts remaining copy words
`define ECS_BANK_CYCLE   64
`define ECS_READ_MISS    23
`define ECS_READ_HIT     6
`define ECS_READ_LOCK    15
`define ECS_WRITE_TIME   3
`define ECS_NEAR_END     4
// ==========================================================
// Register byte offsets
`define ECS_REG_CONTROL  5'h00
`define ECS_REG_STATUS   5'h04
`define ECS_REG_ERR_ADDR 5'h08
`define ECS_REG_SYNDROME 5'h0C
`define ECS_REG_CLEAR    5'h10
// ==========================================================
// Control fields
`define ECS_CTL_PARITY   0
`define ECS_CTL_MAINT    1
`define ECS_CTL_TEST     2
`define ECS_CTL_INHIBIT  3
`define ECS_CTL_TCOMP    4
`define ECS_CTL_REPORT   5
`define ECS_CTL_CFG_LSB  8
`define ECS_CTL_RESET    16'h0200
// ==========================================================
// Status and clear fields
`define ECS_ST_LOCKED    0
`define ECS_ST_SINGLE    1
`define ECS_ST_UNCORR    2
`define ECS_ST_FLAG      3
`define ECS_CLR_LOCK     0
`define ECS_CLR_SINGLE   1
`define ECS_CLR_UNCORR   2
`endif

// File: include/ecs_pkg.sv
package ecs_pkg;
   typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_COPY_OUT, OP_COPY_IN} op_t;
   typedef enum logic [2:0] {ST_IDLE, ST_CHECK, ST_HOLD, ST_COPY_OUT, ST_COPY_IN} state_t;
endpackage : ecs_pkg

// File: hdl/extended_core_store.sv
`timescale 1ns/1ps
`include "ecs_map.svh"
module extended_core_store #(
   parameter int NUM_BANKS = 8,
   parameter int LINE_W    = 14
) (
   input  wire logic                clock,
   input  wire logic                rst,
   input  wire logic [4:0]          avs_address,
   input  wire logic                avs_read,
   input  wire logic                avs_write,
   input  wire logic [31:0]         avs_writedata,
   input  wire logic [3:0]          avs_byteenable,
   output logic      [31:0]         avs_readdata,
   output logic                     avs_waitrequest,
   input  wire logic                req_valid,
   input  wire ecs_pkg::op_t        req_op,
   input  wire logic [20:0]         req_address,
   input  wire logic [20:0]         req_count,
   input  wire logic [59:0]         req_wdata,
   output logic                     req_ready,
   output logic                     op_done,
   output logic      [59:0]         read_data,
   input  wire logic                cm_in_valid,
   input  wire logic [59:0]         cm_in_data,
   output logic                     cm_in_ready,
   output logic                     cm_out_valid,
   output logic      [59:0]         cm_out_data,
   output logic                     cpu_halt,
   output logic                     error_flag,
   input  wire logic                error_flag_clear
);
   import ecs_pkg::*;

   if (!(NUM_BANKS == 2 || NUM_BANKS == 4 || NUM_BANKS == 8) || LINE_W < 1 || LINE_W > 14) begin : g_bad
      $error("extended_core_store: unsupported NUM_BANKS or LINE_W");
   end

   localparam logic [2:0] INST_CFG = (NUM_BANKS == 2) ? 3'h0 : (NUM_BANKS == 4) ? 3'h1 : 3'h2;
   localparam logic [7:0] LAT_MISS = 8'(`ECS_READ_MISS - 2);
   localparam logic [7:0] LAT_HIT  = 8'(`ECS_READ_HIT - 2);
   localparam logic [7:0] LAT_LOCK = 8'(`ECS_READ_LOCK - 2);
   localparam logic [7:0] LAT_WR   = 8'(`ECS_WRITE_TIME - 2);

   // ==========================================================
   // Word coding functions
   function automatic logic [7:0] gen_check(input logic [59:0] d);
      logic [6:0] s;
      logic [6:0] p;
      s = 7'h00;
      p = 7'h02;
      for (int k = 0; k < `ECS_DATA_W; k++) begin
         p = p + 7'h01;
         if ((p & (p - 7'h01)) == 7'h00) p = p + 7'h01;
         if (d[k]) s = s ^ p;
      end
      return {^{d, s}, s};
   endfunction : gen_check

   function automatic logic [7:0] gen_par(input logic [59:0] d);
      logic [7:0] r;
      r = 8'h00;
      for (int j = 0; j < 8; j++) r[j] = ^(8'(d >> (8 * j)));
      return r;
   endfunction : gen_par

   function automatic logic [4:0] ones(input logic [29:0] h);
      logic [4:0] n;
      n = 5'h00;
      for (int k = 0; k < `ECS_HALF_W; k++) n = n + 5'(h[k]);
      return n;
   endfunction : ones

   // Halves are stored complemented when mostly ones, which keeps core drive currents balanced.
   function automatic logic [71:0] encode(input logic [59:0] d, input logic par, input logic tst);
      logic [1:0]  cc;
      logic [59:0] s;
      logic [7:0]  chk;
      cc[0] = ones(d[29:0]) > 5'h0F;
      cc[1] = ones(d[59:30]) > 5'h0F;
      s = {cc[1] ? ~d[59:30] : d[59:30], cc[0] ? ~d[29:0] : d[29:0]};
      chk = par ? gen_par(s) : gen_check(s);
      if (tst) chk = par ? ~chk : 8'h00;
      return {2'b00, cc, chk, s};
   endfunction : encode

   function automatic void check_word(input logic [71:0] w, input logic par, input logic tcomp,
                                      output logic [59:0] d, output logic sgl, output logic dbl,
                                      output logic perr, output logic [7:0] syn);
      logic [7:0] g;
      logic [6:0] p;
      d = w[59:0];
      g = par ? gen_par(d) : gen_check(d);
      sgl = 1'b0;
      dbl = 1'b0;
      perr = 1'b0;
      if (par) begin
         syn = g ^ w[67:60];
         perr = syn != 8'h00;
      end else begin
         syn = {^{d, w[67:60]}, g[6:0] ^ w[66:60]};
         sgl = syn[7];
         dbl = !syn[7] && syn[6:0] != 7'h00;
         p = 7'h02;
         for (int k = 0; k < `ECS_DATA_W; k++) begin
            p = p + 7'h01;
            if ((p & (p - 7'h01)) == 7'h00) p = p + 7'h01;
            if (sgl && p == syn[6:0]) d[k] = ~d[k];
         end
      end
      if (!tcomp) d = {w[69] ? ~d[59:30] : d[59:30], w[68] ? ~d[29:0] : d[29:0]};
   endfunction : check_word

   function automatic logic [2:0] addr_bank(input logic [20:0] a, input logic [2:0] cfg);
      case (cfg)
         3'h0:    return {2'b00, a[4]};
         3'h1:    return {1'b0, a[5:4]};
         default: return {a[20], a[5:4]};
      endcase
   endfunction : addr_bank

   function automatic logic [13:0] addr_line(input logic [20:0] a, input logic [2:0] cfg);
      return (cfg == 3'h0) ? a[18:5] : a[19:6];
   endfunction : addr_line

   // ==========================================================
   // Declarations
   state_t      state;
   state_t      next_state;
   op_t         op;
   logic [20:0] addr;
   logic [20:0] remaining;
   logic [20:0] next_remaining;
   logic [20:0] next_addr;
   logic [59:0] wdata;
   logic [7:0]  lat;
   logic [7:0]  target;
   logic [71:0] raw_hold;
   logic [15:0] ctl;
   logic        locked;
   logic [20:0] err_addr;
   logic [7:0]  syndrome;
   logic        sticky_single;
   logic        sticky_uncorr;
   logic        wr_acc;
   logic [71:0] store [NUM_BANKS][2**LINE_W][`ECS_LINE_WORDS];
   logic [71:0] buf_w [NUM_BANKS][`ECS_LINE_WORDS];
   logic [13:0] tag [NUM_BANKS];
   logic        tag_valid [NUM_BANKS];
   logic [6:0]  busy_cnt [NUM_BANKS];
   logic [2:0]  cfg;
   logic [2:0]  cur_bank;
   logic [13:0] cur_line;
   logic [3:0]  cur_word;
   logic        hit;
   logic        busy;
   logic [2:0]  nx_bank;
   logic        nx_hit;
   logic        load_en;
   logic        wr_en;
   logic        emit;
   logic        decide;
   logic        taken;
   logic        start;
   logic        finish;
   logic        deliver;
   logic [71:0] wr_enc;
   logic [71:0] chk_word;
   logic [59:0] chk_data;
   logic        chk_sgl;
   logic        chk_dbl;
   logic        chk_perr;
   logic [7:0]  chk_syn;
   logic        err_hit;
   logic        log_single;
   logic        clr_lock;

   // ==========================================================
   // Address decode and buffer lookup
   assign cfg      = (ctl[10:8] > INST_CFG) ? INST_CFG : ctl[10:8];
   assign cur_bank = addr_bank(addr, cfg);
   assign cur_line = addr_line(addr, cfg);
   assign cur_word = addr[3:0];
   assign hit      = tag_valid[cur_bank] && tag[cur_bank] == cur_line;
   assign busy     = busy_cnt[cur_bank] != 7'h00;
   assign taken    = cm_in_valid && cm_in_ready;
   assign start    = load_en || (wr_en && !busy);
   assign nx_bank  = addr_bank(next_addr, cfg);
   assign nx_hit   = (tag_valid[nx_bank] && tag[nx_bank] == addr_line(next_addr, cfg))
                     || (load_en && nx_bank == cur_bank && addr_line(next_addr, cfg) == cur_line);
   assign wr_enc   = encode(op == OP_WRITE ? wdata : cm_in_data, ctl[`ECS_CTL_PARITY], ctl[`ECS_CTL_TEST]);
   assign chk_word = (state == ST_COPY_OUT) ? buf_w[cur_bank][cur_word] : raw_hold;
   assign finish   = state == ST_HOLD && lat == target;
   assign deliver  = emit || (finish && op == OP_READ);

   always_comb begin
      check_word(chk_word, ctl[`ECS_CTL_PARITY], ctl[`ECS_CTL_TCOMP], chk_data, chk_sgl, chk_dbl, chk_perr, chk_syn);
   end

   // ==========================================================
   // Sequencing decisions
   always_comb begin
      load_en = 1'b0;
      wr_en = 1'b0;
      emit = 1'b0;
      decide = 1'b0;
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (req_valid && req_ready) begin
               case (req_op)
                  OP_COPY_OUT: next_state = ST_COPY_OUT;
                  OP_COPY_IN:  next_state = ST_COPY_IN;
                  default:     next_state = ST_CHECK;
               endcase
            end
         end
         ST_CHECK: begin
            if (hit || !busy) begin
               decide = 1'b1;
               load_en = !hit;
               wr_en = op == OP_WRITE;
               next_state = ST_HOLD;
            end
         end
         ST_HOLD: begin
            if (finish) next_state = ST_IDLE;
         end
         ST_COPY_OUT: begin
            if (remaining == 21'h0) next_state = ST_IDLE;
            else if (hit) emit = 1'b1;
            else if (!busy) load_en = 1'b1;
         end
         ST_COPY_IN: begin
            if (remaining == 21'h0) next_state = ST_IDLE;
            else if (taken) wr_en = 1'b1;
            else if (!hit && !busy) load_en = 1'b1;
         end
         default: next_state = ST_IDLE;
      endcase
      next_addr = addr + 21'(emit || taken);
      next_remaining = remaining - 21'(emit || taken);
   end

   // ==========================================================
   // Request engine
   always_ff @(posedge clock) begin
      if (rst) begin
         state <= ST_IDLE;
         op <= OP_READ;
         addr <= 21'h0;
         remaining <= 21'h0;
         wdata <= 60'h0;
         lat <= 8'h00;
         target <= 8'h00;
         raw_hold <= 72'h0;
      end else begin
         state <= next_state;
         lat <= lat + 8'h01;
         if (state == ST_IDLE && req_valid && req_ready) begin
            op <= req_op;
            addr <= req_address;
            remaining <= req_count;
            wdata <= req_wdata;
            lat <= 8'h00;
         end else begin
            addr <= next_addr;
            remaining <= next_remaining;
         end
         if (decide) begin
            raw_hold <= hit ? buf_w[cur_bank][cur_word] : store[cur_bank][cur_line[LINE_W-1:0]][cur_word];
            if (op == OP_WRITE) target <= lat + LAT_WR;
            else target <= lat + (!hit ? LAT_MISS : busy ? LAT_LOCK : LAT_HIT);
         end
      end
   end

   // Ready and halt outputs are computed from the next state so that they leave flip-flops.
   always_ff @(posedge clock) begin
      if (rst) begin
         req_ready <= 1'b0;
         op_done <= 1'b0;
         read_data <= 60'h0;
         cm_in_ready <= 1'b0;
         cm_out_valid <= 1'b0;
         cm_out_data <= 60'h0;
         cpu_halt <= 1'b0;
      end else begin
         req_ready <= next_state == ST_IDLE;
         op_done <= finish || ((state == ST_COPY_OUT || state == ST_COPY_IN) && remaining == 21'h0);
         if (finish && op == OP_READ) read_data <= chk_data;
         cm_in_ready <= next_state == ST_COPY_IN && next_remaining != 21'h0 && nx_hit;
         cm_out_valid <= emit;
         if (emit) cm_out_data <= chk_data;
         cpu_halt <= (next_state == ST_COPY_OUT || next_state == ST_COPY_IN)
                     && next_remaining > 21'(`ECS_NEAR_END);
      end
   end

   // ==========================================================
   // Banks, line buffers and storage
   always_ff @(posedge clock) begin
      for (int b = 0; b < NUM_BANKS; b++) begin
         if (rst) busy_cnt[b] <= 7'h00;
         else if (start && cur_bank == 3'(b)) busy_cnt[b] <= 7'(`ECS_BANK_CYCLE - 1);
         else if (busy_cnt[b] != 7'h00) busy_cnt[b] <= busy_cnt[b] - 7'h01;
      end
   end

   always_ff @(posedge clock) begin
      for (int b = 0; b < NUM_BANKS; b++) begin
         if (rst) begin
            tag_valid[b] <= 1'b0;
            tag[b] <= 14'h0;
         end else if (load_en && cur_bank == 3'(b)) begin
            tag_valid[b] <= 1'b1;
            tag[b] <= cur_line;
         end
      end
   end

   // The whole line moves at once, so later reads of it cost no new bank cycle.
   always_ff @(posedge clock) begin
      if (load_en) begin
         for (int w = 0; w < `ECS_LINE_WORDS; w++) begin
            buf_w[cur_bank][w] <= (wr_en && cur_word == 4'(w)) ? wr_enc
                                  : store[cur_bank][cur_line[LINE_W-1:0]][w];
         end
      end else if (wr_en) begin
         buf_w[cur_bank][cur_word] <= wr_enc;
      end
   end

   // Writes go straight through to the bank, so a buffer line is never dirty.
   always_ff @(posedge clock) begin
      if (wr_en) store[cur_bank][cur_line[LINE_W-1:0]][cur_word] <= wr_enc;
   end

   // ==========================================================
   // Error detection and capture
   assign err_hit = deliver && (ctl[`ECS_CTL_PARITY] ? (chk_perr && !locked)
                    : (chk_dbl || (chk_sgl && ctl[`ECS_CTL_MAINT])));
   assign log_single = deliver && !ctl[`ECS_CTL_PARITY] && chk_sgl && !ctl[`ECS_CTL_MAINT]
                       && ctl[`ECS_CTL_REPORT] && !ctl[`ECS_CTL_INHIBIT];
   assign wr_acc   = avs_write && !avs_waitrequest;
   assign clr_lock = wr_acc && avs_address == `ECS_REG_CLEAR && avs_byteenable[0]
                     && avs_writedata[`ECS_CLR_LOCK];

   // Copy-out words keep being checked after the halt lifts, so late errors still exit.
   always_ff @(posedge clock) begin
      if (rst) error_flag <= 1'b0;
      else if (err_hit) error_flag <= 1'b1;
      else if (error_flag_clear) error_flag <= 1'b0;
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         locked <= 1'b0;
         err_addr <= 21'h0;
         syndrome <= 8'h00;
      end else if (err_hit && !locked) begin
         locked <= 1'b1;
         err_addr <= addr;
         syndrome <= chk_syn;
      end else if (clr_lock) begin
         locked <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         sticky_single <= 1'b0;
         sticky_uncorr <= 1'b0;
      end else begin
         if (log_single) sticky_single <= 1'b1;
         else if (wr_acc && avs_address == `ECS_REG_CLEAR && avs_byteenable[0]
                  && avs_writedata[`ECS_CLR_SINGLE]) sticky_single <= 1'b0;
         if (err_hit) sticky_uncorr <= 1'b1;
         else if (wr_acc && avs_address == `ECS_REG_CLEAR && avs_byteenable[0]
                  && avs_writedata[`ECS_CLR_UNCORR]) sticky_uncorr <= 1'b0;
      end
   end

   // ==========================================================
   // Register bus slave
   always_ff @(posedge clock) begin
      if (rst) avs_waitrequest <= 1'b1;
      else avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         ctl <= `ECS_CTL_RESET;
      end else if (wr_acc && avs_address == `ECS_REG_CONTROL) begin
         if (avs_byteenable[0]) ctl[7:0] <= avs_writedata[7:0];
         if (avs_byteenable[1]) ctl[15:8] <= avs_writedata[15:8];
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         avs_readdata <= 32'h00000000;
      end else if (avs_read && avs_waitrequest) begin
         case (avs_address)
            `ECS_REG_CONTROL:  avs_readdata <= {16'h0000, ctl};
            `ECS_REG_STATUS:   avs_readdata <= {28'h0000000, error_flag, sticky_uncorr, sticky_single, locked};
            `ECS_REG_ERR_ADDR: avs_readdata <= {11'h000, err_addr};
            `ECS_REG_SYNDROME: avs_readdata <= {24'h000000, syndrome};
            default:           avs_readdata <= 32'h00000000;
         endcase
      end
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   bank_cycle_a: assert property (start && cur_bank == 3'h0 |-> ##63 busy_cnt[0] != 7'h00 ##1 busy_cnt[0] == 7'h00)
      else $error("bank cycle length wrong");
   hit_read_a: assert property (decide && op == OP_READ && hit && !busy |-> ##5 op_done)
      else $error("buffer hit read not done in time");
   lock_read_a: assert property (decide && op == OP_READ && hit && busy |-> ##14 op_done)
      else $error("lockout read not done in time");
   miss_read_a: assert property (decide && op == OP_READ && !hit |-> ##22 op_done)
      else $error("miss read not done in time");
   write_time_a: assert property (decide && op == OP_WRITE |-> ##2 op_done)
      else $error("write not done in time");
   error_flag_a: assert property (err_hit |=> error_flag && sticky_uncorr)
      else $error("error flag not raised");
   lock_hold_a: assert property (locked && !clr_lock |=> $stable(err_addr) && $stable(syndrome))
      else $error("locked error capture changed");
   single_quiet_a: assert property (!ctl[`ECS_CTL_REPORT] || ctl[`ECS_CTL_INHIBIT] |=> !$rose(sticky_single))
      else $error("single error logged while suppressed");
   halt_ready_a: assert property (cpu_halt |-> !req_ready)
      else $error("request accepted during copy");
   test_zero_a: assert property (wr_en && ctl[`ECS_CTL_TEST] && !ctl[`ECS_CTL_PARITY] |-> wr_enc[67:60] == 8'h00)
      else $error("test mode check bits not zero");

   miss_read_c: cover property (decide && op == OP_READ && !hit ##22 op_done);
   copy_out_c:  cover property (state == ST_COPY_OUT && remaining > 21'h4 ##1 (cm_out_valid [*4]));
   error_lock_c: cover property (err_hit && !locked ##[1:40] clr_lock);
   write_wait_c: cover property (state == ST_CHECK && op == OP_WRITE && busy && !hit);

endmodule : extended_core_store

// File: test/cm_model.sv
`timescale 1ns/1ps
// ==========
// Central memory source for copies into the store.
module cm_model (
   input  wire logic        clock,
   input  wire logic        active,
   input  wire logic        cm_in_ready,
   output logic             cm_in_valid,
   output logic      [59:0] cm_in_data
);
   logic [59:0] mem [0:19];
   int          nxt;
   logic        v;
   // Random stalls; an idle data line shows the inverse so stale words never look valid.
   always @(posedge clock) begin
      if (!active) begin
         nxt = 0;
         cm_in_valid <= 1'b0;
         cm_in_data <= '0;
      end else if (!cm_in_valid || cm_in_ready) begin
         nxt = nxt + (cm_in_valid ? 1 : 0);
         v = (nxt < 20) && ($urandom_range(3) != 0);
         cm_in_valid <= v;
         cm_in_data <= v ? mem[nxt] : ~cm_in_data;
      end
   end
endmodule : cm_model

// File: test/extended_core_store_tb.sv
`timescale 1ns/1ps
`include "ecs_map.svh"
module extended_core_store_tb;
   import ecs_pkg::*;
   logic        clock, rst, avs_read, avs_write, avs_waitrequest, req_valid, req_ready, op_done;
   logic        cm_in_valid, cm_in_ready, cm_out_valid, cpu_halt, error_flag, error_flag_clear;
   logic        copy_on, reading;
   logic [4:0]  avs_address;
   logic [3:0]  avs_byteenable;
   logic [31:0] avs_writedata, avs_readdata, q;
   op_t         req_op;
   logic [20:0] req_address, req_count;
   logic [59:0] req_wdata, read_data, cm_in_data, cm_out_data, d;
   logic [59:0] rq[$], cq[$];
   int          n_errors = 0, n_compared = 0, n_out = 0, lat;
   // ==========
   // Design, far side and clock.
   extended_core_store #(.NUM_BANKS(8), .LINE_W(3)) u_dut (.clock, .rst, .avs_address, .avs_read,
      .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .req_valid,
      .req_op, .req_address, .req_count, .req_wdata, .req_ready, .op_done, .read_data, .cm_in_valid,
      .cm_in_data, .cm_in_ready, .cm_out_valid, .cm_out_data, .cpu_halt, .error_flag, .error_flag_clear);
   cm_model u_cm (.clock, .active(copy_on), .cm_in_ready, .cm_in_valid, .cm_in_data);
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // ==========
   // Shared tasks.
   task automatic compare(input string what, input logic [63:0] exp, input logic [63:0] got);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
      end
   endtask : compare
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
      @(posedge clock);
      avs_address <= a;
      avs_writedata <= wd;
      avs_write <= wr;
      avs_read <= !wr;
      do @(posedge clock); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus
   task automatic op(input op_t o, input logic [20:0] a, input logic [20:0] n, input logic chk);
      @(posedge clock);
      if (chk) rq.push_back(d);
      reading <= chk;
      req_op <= o;
      req_address <= a;
      req_count <= n;
      req_wdata <= d;
      req_valid <= 1'b1;
      do @(posedge clock); while (req_ready !== 1'b1);
      req_valid <= 1'b0;
      lat = 0;
      do begin
         @(posedge clock);
         lat++;
      end while (op_done !== 1'b1);
      reading <= 1'b0;
   endtask : op
   task automatic close_out;
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : close_out
   // ==========
   // Result monitor.
   always @(posedge clock) begin
      if (cm_out_valid === 1'b1) begin
         if (n_out == 0) compare("cpu_halt", 1, cpu_halt);
         compare("cm_out_data", cq.pop_front(), cm_out_data);
         n_out++;
      end
      if (op_done === 1'b1 && reading) compare("read_data", rq.pop_front(), read_data);
   end
   // ==========
   // Tests.
   initial begin
      {rst, avs_read, avs_write, req_valid, error_flag_clear, copy_on, reading} = 7'h40;
      {avs_address, avs_writedata, req_address, req_count, req_wdata, d} = '0;
      avs_byteenable = 4'hF;
      req_op = OP_READ;
      void'($urandom(32'hF56880D5));
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      bus(0, `ECS_REG_CONTROL, 0);
      compare("control", `ECS_CTL_RESET, q);
      bus(0, 5'h14, 0);
      compare("unmapped", 0, q);
      bus(1, `ECS_REG_CONTROL, 32'h0200);
      $display("test registers done");
      d = 60'({$urandom, $urandom});
      op(OP_WRITE, 21'h000040, 0, 0);
      compare("write_time", 3, lat);
      op(OP_READ, 21'h000040, 0, 1);
      compare("lock_time", 15, lat);
      op(OP_READ, 21'h000010, 0, 0);
      compare("miss_time", 23, lat);
      repeat (70) @(posedge clock);
      op(OP_READ, 21'h000010, 0, 0);
      compare("hit_time", 6, lat);
      op(OP_READ, 21'h000040, 0, 1);
      $display("test timing done");
      for (int i = 0; i < 20; i++) u_cm.mem[i] = 60'({$urandom, $urandom});
      copy_on <= 1'b1;
      op(OP_COPY_IN, 21'h000080, 21'd20, 0);
      copy_on <= 1'b0;
      for (int i = 0; i < 20; i++) cq.push_back(u_cm.mem[i]);
      op(OP_COPY_OUT, 21'h000080, 21'd20, 0);
      compare("copy_words", 20, n_out);
      compare("halt_end", 0, cpu_halt);
      $display("test copy done");
      bus(1, `ECS_REG_CONTROL, 32'h0205);
      d = 60'({$urandom, $urandom});
      op(OP_WRITE, 21'h000100, 0, 0);
      bus(1, `ECS_REG_CONTROL, 32'h0201);
      for (int k = 0; k < 3; k++) begin
         if (k == 1) error_flag_clear <= 1'b1;
         if (k == 2) bus(1, `ECS_REG_CLEAR, 32'h1);
         repeat (70) @(posedge clock);
         error_flag_clear <= 1'b0;
         op(OP_READ, 21'h000100, 0, 1);
         compare("parity_time", 6, lat);
         repeat (3) @(posedge clock);
         compare("error_flag", k != 1, error_flag);
      end
      bus(0, `ECS_REG_STATUS, 0);
      compare("status", 4'hD, q[3:0]);
      bus(0, `ECS_REG_ERR_ADDR, 0);
      compare("err_addr", 21'h000100, q[20:0]);
      $display("test parity done");
      error_flag_clear <= 1'b1;
      bus(1, `ECS_REG_CLEAR, 32'h7);
      error_flag_clear <= 1'b0;
      bus(1, `ECS_REG_CONTROL, 32'h0204);
      d = 60'h7;
      op(OP_WRITE, 21'h000200, 0, 0);
      d = 60'h9;
      op(OP_WRITE, 21'h000201, 0, 0);
      d = 60'h7;
      bus(1, `ECS_REG_CONTROL, 32'h0228);
      op(OP_READ, 21'h000200, 0, 1);
      bus(0, `ECS_REG_STATUS, 0);
      compare("inhibit_status", 4'h0, q[3:0]);
      bus(1, `ECS_REG_CONTROL, 32'h0220);
      op(OP_READ, 21'h000200, 0, 1);
      bus(0, `ECS_REG_STATUS, 0);
      compare("single_status", 4'h2, q[3:0]);
      bus(1, `ECS_REG_CONTROL, 32'h0200);
      d = 60'h9;
      op(OP_READ, 21'h000201, 0, 1);
      bus(0, `ECS_REG_STATUS, 0);
      compare("double_status", 4'hF, q[3:0]);
      bus(0, `ECS_REG_SYNDROME, 0);
      compare("double_syndrome", 8'h04, q[7:0]);
      bus(0, `ECS_REG_ERR_ADDR, 0);
      compare("double_addr", 21'h000201, q[20:0]);
      error_flag_clear <= 1'b1;
      bus(1, `ECS_REG_CLEAR, 32'h7);
      error_flag_clear <= 1'b0;
      bus(1, `ECS_REG_CONTROL, 32'h0202);
      d = 60'h7;
      op(OP_READ, 21'h000200, 0, 1);
      bus(0, `ECS_REG_STATUS, 0);
      compare("maint_status", 4'hD, q[3:0]);
      bus(0, `ECS_REG_SYNDROME, 0);
      compare("maint_syndrome", 8'h80, q[7:0]);
      d = 60'h3FFFFFFF;
      op(OP_WRITE, 21'h000202, 0, 0);
      bus(1, `ECS_REG_CONTROL, 32'h0210);
      d = 60'h0;
      op(OP_READ, 21'h000202, 0, 1);
      $display("test secded done");
      close_out();
   end
   initial begin
      repeat (20000) @(posedge clock);
      n_errors++;
      close_out();
   end
endmodule : extended_core_store_tb
